//--- mxp_pkg.sv
// constants, field layouts and carrier types of the management page logic
// assumes a single 250 MHz clock and an active-low asynchronous reset
// What this block does
// R01 - page bit one steers 16..30 to extended
// R02 - addresses 0..15 ignore page bit
// R03 - extended page offers fifteen registers
// R04 - page select register always reads zero
// R05 - fiber remote fault bits read only
// R06 - partner pause abilities shown, read only
// R07 - partner duplex abilities shown, read only
// R08 - restart bit self clears, reads zero
// R09 - completion bit shows finished negotiation
// R10 - autosense disable, mode reset, sticky
// R11 - mapping mask writable, resets 01, sticky
// R12 - combining bit writable, resets one, sticky
// R13 - swing code 400mV..1.6V, reset 100
// R14 - reserved bits read zero, ignore writes
// R15 - page select resets to zero
package mxp_pkg;

    // ------------------------------------------------------------------
    // address map
    // ------------------------------------------------------------------
    localparam logic [4:0] MXP_ADDR_FANC   = 5'h10; // fiber autoneg reg
    localparam logic [4:0] MXP_ADDR_SIF    = 5'h11; // serial if control
    localparam logic [4:0] MXP_ADDR_PAGE   = 5'h1f; // page select
    localparam logic [4:0] MXP_ADDR_UPLO   = 5'h10; // first paged slot
    localparam logic [4:0] MXP_ADDR_UPHI   = 5'h1e; // last paged slot
    localparam int         MXP_EXT_COUNT   = 15;    // extended slots

    // ------------------------------------------------------------------
    // fiber autoneg register fields
    // ------------------------------------------------------------------
    localparam int MXP_FANC_RF_HI    = 13;
    localparam int MXP_FANC_RF_LO    = 12;
    localparam int MXP_FANC_ASYM     = 11;
    localparam int MXP_FANC_SYM      = 10;
    localparam int MXP_FANC_RESTART  = 9;
    localparam int MXP_FANC_FDX      = 8;
    localparam int MXP_FANC_HDX      = 7;
    localparam int MXP_FANC_DONE     = 5;
    localparam int MXP_FANC_ASDIS    = 4;
    localparam int MXP_FANC_MASK_HI  = 2;
    localparam int MXP_FANC_MASK_LO  = 1;
    localparam int MXP_FANC_OR       = 0;

    localparam logic [1:0] MXP_RST_MASK = 2'h1;
    localparam logic       MXP_RST_OR   = 1'h1;

    // ------------------------------------------------------------------
    // serial interface control fields
    // ------------------------------------------------------------------
    localparam int MXP_SIF_SW_HI   = 4;
    localparam int MXP_SIF_SW_LO   = 2;
    localparam int MXP_SIF_HYST    = 1;
    localparam int MXP_SIF_CLKEN   = 0;

    localparam logic [2:0] MXP_RST_SWING = 3'h4;
    localparam logic [2:0] MXP_SWING_MAX = 3'h6; // 1.6V, 111 aliases it
    localparam logic       MXP_RST_CLKEN = 1'h1;

    // ------------------------------------------------------------------
    // page select field
    // ------------------------------------------------------------------
    localparam int   MXP_PAGE_BIT = 0;
    localparam logic MXP_RST_PAGE = 1'h0;

    localparam logic [15:0] MXP_ZERO16 = 16'h0000;

    // ------------------------------------------------------------------
    // carrier types
    // ------------------------------------------------------------------
    typedef struct packed {
        logic        rd;
        logic        wr;
        logic [4:0]  addr;
        logic [15:0] wdata;
    } mxp_mgmt_req_s;

    typedef struct packed {
        logic [1:0] rfault;
        logic       asym_pause;
        logic       sym_pause;
        logic       full_dpx;
        logic       half_dpx;
    } mxp_lp_abil_s;

    typedef struct packed {
        logic std;
        logic fanc;
        logic sif;
        logic page;
        logic ext_other;
    } mxp_hit_s;

endpackage : mxp_pkg

//--- mxp_page_decode.sv
// address decoder that applies the page select bit
// assumes the address is stable while a strobe is high
module mxp_page_decode (
    input  wire logic [4:0]       addr,
    input  wire logic             page_ext,
    output mxp_pkg::mxp_hit_s     hit
);

    logic upper;

    // only the paged window looks at the page bit
    always_comb begin
        upper         = (addr >= mxp_pkg::MXP_ADDR_UPLO) &&
                        (addr <= mxp_pkg::MXP_ADDR_UPHI);
        hit           = '0;
        hit.page      = (addr == mxp_pkg::MXP_ADDR_PAGE);
        hit.std       = !upper && !hit.page;             // [R02]
        if (upper && !page_ext) begin
            hit.std = 1'b1;                              // [R01]
        end
        if (upper && page_ext) begin
            // fifteen slots, two backed here, rest reserved [R03]
            hit.fanc      = (addr == mxp_pkg::MXP_ADDR_FANC); // [R01]
            hit.sif       = (addr == mxp_pkg::MXP_ADDR_SIF);
            hit.ext_other = !hit.fanc && !hit.sif;
        end
    end

endmodule : mxp_page_decode

//--- mxp_sc_pulse.sv
// self-clearing command bit turned into a one-cycle pulse
// assumes trig is a one-cycle write qualifier
module mxp_sc_pulse (
    input  wire logic sys_clk,
    input  wire logic nrst,
    input  wire logic trig,
    output logic      pulse
);

    logic pulse_reg;
    logic pulse_next;

    // nothing is stored beyond one cycle, so readback stays zero
    always_comb begin
        pulse_next = trig;                               // [R08]
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            pulse_reg <= 1'b0;
        end else begin
            pulse_reg <= pulse_next;
        end
    end

    assign pulse = pulse_reg;

endmodule : mxp_sc_pulse

//--- mxp_regs.sv
// management registers: page select, fiber autoneg, serial if control
// assumes one request per cycle at most and a combinational standard
// register set answering std_rdata in the cycle of its read strobe
module mxp_regs (
    input  wire logic                 sys_clk,
    input  wire logic                 nrst,
    input  wire logic                 soft_rst,
    input  wire logic                 strap_autosense_dis,
    input  wire logic                 strap_serial_mac,
    input  wire mxp_pkg::mxp_mgmt_req_s mgmt_req,
    output logic [15:0]               mgmt_rdata,
    output logic                      mgmt_rvalid,
    output logic                      std_rd,
    output logic                      std_wr,
    output logic [4:0]                std_addr,
    output logic [15:0]               std_wdata,
    input  wire logic [15:0]          std_rdata,
    input  wire logic                 lp_abil_valid,
    input  wire mxp_pkg::mxp_lp_abil_s lp_abil,
    input  wire logic                 an_complete,
    output logic                      an_restart,
    output logic                      autosense_dis,
    output logic [1:0]                rf_map_mask,
    output logic                      rf_map_or,
    output logic [2:0]                serial_swing_code,
    output logic [2:0]                serial_swing_level,
    output logic                      hyst_dis,
    output logic                      aux_clock_output_en,
    output logic                      page_ext
);

    // ------------------------------------------------------------------
    // decode
    // ------------------------------------------------------------------
    mxp_pkg::mxp_hit_s hit;
    logic              wr_fanc;
    logic              wr_sif;
    logic              wr_page;
    logic              restart_trig;

    mxp_page_decode u_dec (
        .addr     (mgmt_req.addr),
        .page_ext (page_ext),
        .hit      (hit)
    );

    // write qualifiers per target
    always_comb begin
        wr_fanc      = mgmt_req.wr && hit.fanc;
        wr_sif       = mgmt_req.wr && hit.sif;
        wr_page      = mgmt_req.wr && hit.page;
        restart_trig = wr_fanc &&
                       mgmt_req.wdata[mxp_pkg::MXP_FANC_RESTART]; // [R08]
    end

    // standard set is reached straight through, slots 16..30 only while the page bit is zero
    assign std_rd    = mgmt_req.rd && hit.std;           // [R02]
    assign std_wr    = mgmt_req.wr && hit.std;           // [R01]
    assign std_addr  = mgmt_req.addr;
    assign std_wdata = mgmt_req.wdata;

    mxp_sc_pulse u_restart (
        .sys_clk (sys_clk),
        .nrst    (nrst),
        .trig    (restart_trig),
        .pulse   (an_restart)
    );

    // ------------------------------------------------------------------
    // strap capture
    // ------------------------------------------------------------------
    // straps are sampled on the first edge after release, never by reset
    logic strap_done_reg;
    logic strap_done_next;
    logic strap_asdis_reg;
    logic strap_asdis_next;
    logic strap_ser_reg;
    logic strap_ser_next;

    always_comb begin
        strap_done_next  = 1'b1;
        strap_asdis_next = strap_done_reg ? strap_asdis_reg
                                          : strap_autosense_dis;
        strap_ser_next   = strap_done_reg ? strap_ser_reg
                                          : strap_serial_mac;
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            strap_done_reg  <= 1'b0;
            strap_asdis_reg <= 1'b0;
            strap_ser_reg   <= 1'b0;
        end else begin
            strap_done_reg  <= strap_done_next;
            strap_asdis_reg <= strap_asdis_next;
            strap_ser_reg   <= strap_ser_next;
        end
    end

    // ------------------------------------------------------------------
    // sticky fields: survive soft reset; only nrst, fiber reg writes and, for asdis, the strap set them
    // ------------------------------------------------------------------
    logic       asdis_reg;
    logic       asdis_next;
    logic [1:0] mask_reg;
    logic [1:0] mask_next;
    logic       or_reg;
    logic       or_next;

    always_comb begin
        asdis_next = asdis_reg;
        mask_next  = mask_reg;
        or_next    = or_reg;
        if (!strap_done_reg) begin
            asdis_next = strap_autosense_dis;            // [R10]
        end
        if (wr_fanc) begin
            asdis_next = mgmt_req.wdata[mxp_pkg::MXP_FANC_ASDIS]; // [R10]
            mask_next  = mgmt_req.wdata[mxp_pkg::MXP_FANC_MASK_HI:
                                        mxp_pkg::MXP_FANC_MASK_LO]; // [R11]
            or_next    = mgmt_req.wdata[mxp_pkg::MXP_FANC_OR];      // [R12]
        end
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            asdis_reg <= 1'b0;
            mask_reg  <= mxp_pkg::MXP_RST_MASK;          // [R11]
            or_reg    <= mxp_pkg::MXP_RST_OR;            // [R12]
        end else begin
            asdis_reg <= asdis_next;
            mask_reg  <= mask_next;
            or_reg    <= or_next;
        end
    end

    // ------------------------------------------------------------------
    // non-sticky fields: page select and serial if control
    // ------------------------------------------------------------------
    logic       page_reg;
    logic       page_next;
    logic [2:0] swing_reg;
    logic [2:0] swing_next;
    logic       hyst_reg;
    logic       hyst_next;
    logic       clken_reg;
    logic       clken_next;

    // soft reset wins over a write in the same cycle
    always_comb begin
        page_next  = page_reg;
        swing_next = swing_reg;
        hyst_next  = hyst_reg;
        clken_next = clken_reg;
        if (!strap_done_reg) begin
            hyst_next = strap_serial_mac;                // mode default
        end
        if (wr_page) begin
            page_next = mgmt_req.wdata[mxp_pkg::MXP_PAGE_BIT]; // [R14]
        end
        if (wr_sif) begin
            swing_next = mgmt_req.wdata[mxp_pkg::MXP_SIF_SW_HI:
                                        mxp_pkg::MXP_SIF_SW_LO]; // [R13]
            hyst_next  = mgmt_req.wdata[mxp_pkg::MXP_SIF_HYST];
            clken_next = mgmt_req.wdata[mxp_pkg::MXP_SIF_CLKEN];
        end
        if (soft_rst) begin
            page_next  = mxp_pkg::MXP_RST_PAGE;          // [R15]
            swing_next = mxp_pkg::MXP_RST_SWING;         // [R13]
            hyst_next  = strap_ser_reg;
            clken_next = mxp_pkg::MXP_RST_CLKEN;
        end
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            page_reg  <= mxp_pkg::MXP_RST_PAGE;          // [R15]
            swing_reg <= mxp_pkg::MXP_RST_SWING;         // [R13]
            hyst_reg  <= 1'b0;
            clken_reg <= mxp_pkg::MXP_RST_CLKEN;
        end else begin
            page_reg  <= page_next;
            swing_reg <= swing_next;
            hyst_reg  <= hyst_next;
            clken_reg <= clken_next;
        end
    end

    // ------------------------------------------------------------------
    // partner abilities and completion
    // ------------------------------------------------------------------
    // captured on the partner's valid strobe; cleared by a restart so
    // stale abilities do not outlive a renegotiation
    mxp_pkg::mxp_lp_abil_s lp_reg;
    mxp_pkg::mxp_lp_abil_s lp_next;
    logic                  done_reg;
    logic                  done_next;

    always_comb begin
        lp_next   = lp_reg;
        done_next = an_complete && !restart_trig && !an_restart; // [R09]
        if (restart_trig) begin
            lp_next = '0;
        end
        if (lp_abil_valid) begin
            lp_next = lp_abil;                           // [R05] [R06] [R07]
        end
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            lp_reg   <= '0;
            done_reg <= 1'b0;
        end else begin
            lp_reg   <= lp_next;
            done_reg <= done_next;
        end
    end

    // ------------------------------------------------------------------
    // read data
    // ------------------------------------------------------------------
    logic [15:0] fanc_view;
    logic [15:0] sif_view;
    logic [15:0] rdata_reg;
    logic [15:0] rdata_next;
    logic        rvalid_reg;
    logic        rvalid_next;

    // reserved and restart positions stay zero in the views [R14]
    always_comb begin
        fanc_view = mxp_pkg::MXP_ZERO16;
        fanc_view[mxp_pkg::MXP_FANC_RF_HI:mxp_pkg::MXP_FANC_RF_LO] =
            lp_reg.rfault;                               // [R05]
        fanc_view[mxp_pkg::MXP_FANC_ASYM]  = lp_reg.asym_pause; // [R06]
        fanc_view[mxp_pkg::MXP_FANC_SYM]   = lp_reg.sym_pause;  // [R06]
        fanc_view[mxp_pkg::MXP_FANC_FDX]   = lp_reg.full_dpx;   // [R07]
        fanc_view[mxp_pkg::MXP_FANC_HDX]   = lp_reg.half_dpx;   // [R07]
        fanc_view[mxp_pkg::MXP_FANC_DONE]  = done_reg;          // [R09]
        fanc_view[mxp_pkg::MXP_FANC_ASDIS] = asdis_reg;
        fanc_view[mxp_pkg::MXP_FANC_MASK_HI:mxp_pkg::MXP_FANC_MASK_LO] =
            mask_reg;
        fanc_view[mxp_pkg::MXP_FANC_OR]    = or_reg;
        sif_view = mxp_pkg::MXP_ZERO16;
        sif_view[mxp_pkg::MXP_SIF_SW_HI:mxp_pkg::MXP_SIF_SW_LO] = swing_reg;
        sif_view[mxp_pkg::MXP_SIF_HYST]    = hyst_reg;
        sif_view[mxp_pkg::MXP_SIF_CLKEN]   = clken_reg;
    end

    // answer is registered, one cycle after the read strobe
    always_comb begin
        rvalid_next = mgmt_req.rd;
        rdata_next  = rdata_reg;
        if (mgmt_req.rd) begin
            rdata_next = mxp_pkg::MXP_ZERO16;            // [R04] [R03]
            if (hit.std) begin
                rdata_next = std_rdata;
            end
            if (hit.fanc) begin
                rdata_next = fanc_view;
            end
            if (hit.sif) begin
                rdata_next = sif_view;
            end
        end
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            rdata_reg  <= mxp_pkg::MXP_ZERO16;
            rvalid_reg <= 1'b0;
        end else begin
            rdata_reg  <= rdata_next;
            rvalid_reg <= rvalid_next;
        end
    end

    // ------------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------------
    assign mgmt_rdata          = rdata_reg;
    assign mgmt_rvalid         = rvalid_reg;
    assign autosense_dis       = asdis_reg;              // [R10]
    assign rf_map_mask         = mask_reg;               // [R11]
    assign rf_map_or           = or_reg;                 // [R12]
    assign serial_swing_code   = swing_reg;
    // 111 is the same 1.6V step as 110
    assign serial_swing_level  = (swing_reg > mxp_pkg::MXP_SWING_MAX) ?
                                 mxp_pkg::MXP_SWING_MAX : swing_reg; // [R13]
    assign hyst_dis            = hyst_reg;
    assign aux_clock_output_en = clken_reg;
    assign page_ext            = page_reg;               // [R01]

endmodule : mxp_regs

//--- mxp_far_model.sv
// far side model: standard register set and a fiber link partner
// assumes the bench sets lp_cfg before it restarts negotiation
module mxp_far_model #(
    parameter int DLY = 12
) (
    input  wire logic                  sys_clk,
    input  wire logic                  nrst,
    input  wire logic                  std_rd,
    input  wire logic                  std_wr,
    input  wire logic [4:0]            std_addr,
    input  wire logic [15:0]           std_wdata,
    output logic [15:0]                std_rdata,
    input  wire logic                  an_restart,
    input  wire mxp_pkg::mxp_lp_abil_s lp_cfg,
    output logic                       lp_abil_valid,
    output mxp_pkg::mxp_lp_abil_s      lp_abil,
    output logic                       an_complete
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [15:0] mem [32];
    int          cnt;
    // ------------------------------------------------------------
    // answers
    // ------------------------------------------------------------
    // outside a read or a valid cycle the lines carry junk on purpose
    assign std_rdata = std_rd ? mem[std_addr] : ~mem[std_addr];
    assign lp_abil   = lp_abil_valid ? lp_cfg : ~lp_cfg;
    // negotiation takes DLY cycles after each restart pulse
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            for (int i = 0; i < 32; i++) begin
                mem[i] <= 16'h5a00 | 16'(i);
            end
            cnt           <= 0;
            lp_abil_valid <= 1'b0;
            an_complete   <= 1'b0;
        end else begin
            if (std_wr) begin
                mem[std_addr] <= std_wdata;
            end
            lp_abil_valid <= (cnt == 1);
            if (an_restart) begin
                cnt         <= DLY;
                an_complete <= 1'b0;
            end else if (cnt != 0) begin
                cnt <= cnt - 1;
            end
            if (cnt == 1) begin
                an_complete <= 1'b1;
            end
        end
    end
endmodule : mxp_far_model

//--- mxp_regs_chk.sv
// assertions on the management register ports
// assumes bind to mxp_regs, one clock, nrst as its reset
module mxp_regs_chk (
    input wire logic                  sys_clk, nrst, soft_rst,
    input wire logic                  strap_autosense_dis,
    input wire logic                  strap_serial_mac,
    input wire mxp_pkg::mxp_mgmt_req_s mgmt_req,
    input wire logic [15:0]           mgmt_rdata,
    input wire logic                  mgmt_rvalid, std_rd, std_wr,
    input wire logic [4:0]            std_addr,
    input wire logic [15:0]           std_wdata, std_rdata,
    input wire logic                  lp_abil_valid,
    input wire mxp_pkg::mxp_lp_abil_s lp_abil,
    input wire logic                  an_complete, an_restart,
    input wire logic                  autosense_dis,
    input wire logic [1:0]            rf_map_mask,
    input wire logic                  rf_map_or,
    input wire logic [2:0]            serial_swing_code,
    input wire logic [2:0]            serial_swing_level,
    input wire logic                  hyst_dis, aux_clock_output_en,
    input wire logic                  page_ext
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!nrst);
    logic       rd, wr, up, ext;
    logic [4:0] a;
    // request decode seen from outside
    assign rd  = mgmt_req.rd;
    assign wr  = mgmt_req.wr;
    assign a   = mgmt_req.addr;
    assign up  = (a >= 5'h10) && (a <= 5'h1e);
    assign ext = up && page_ext;
    // ------------------------------------------------------------
    // properties
    // ------------------------------------------------------------
    a_low_std: assert property ((rd || wr) && a < 5'h10 |->
        std_rd == rd && std_wr == wr) else $error("low slot not std");
    a_upper_steer: assert property ((rd || wr) && up |->
        std_rd == (rd && !page_ext) && std_wr == (wr && !page_ext))
        else $error("upper slot steered wrong");
    a_page_zero: assert property (rd && a == 5'h1f |=>
        mgmt_rvalid && mgmt_rdata == 16'h0000) else $error("page read");
    a_rsvd_slots: assert property (rd && ext && a > 5'h11 |=>
        mgmt_rdata == 16'h0000) else $error("reserved slot not zero");
    a_fanc_rsvd: assert property (rd && ext && a == 5'h10 |=>
        mgmt_rdata[15:14] == 2'h0 && !mgmt_rdata[9] && !mgmt_rdata[6]
        && !mgmt_rdata[3]) else $error("fiber reg zero bits");
    a_restart_pulse: assert property (wr && ext && a == 5'h10
        && mgmt_req.wdata[9] && !soft_rst |=> an_restart ##1 !an_restart)
        else $error("restart pulse wrong");
    a_sif_view: assert property (rd && !wr && !soft_rst && ext
        && a == 5'h11 |=> mgmt_rdata == {11'h0, $past(serial_swing_code),
        $past(hyst_dis), $past(aux_clock_output_en)})
        else $error("serial reg view");
    a_fanc_view: assert property (rd && !wr && !soft_rst
        && ext && a == 5'h10 |=> mgmt_rdata[4:0] == {$past(autosense_dis),
        1'b0, $past(rf_map_mask), $past(rf_map_or)})
        else $error("fiber reg control view");
    a_swing_clamp: assert property (serial_swing_level ==
        ((serial_swing_code == 3'h7) ? 3'h6 : serial_swing_code))
        else $error("swing level clamp");
    a_soft_page: assert property (soft_rst |=> !page_ext
        && serial_swing_code == 3'h4) else $error("soft reset values");
    a_sticky_keep: assert property (soft_rst && !wr |=>
        $stable(rf_map_mask) && $stable(rf_map_or)
        && $stable(autosense_dis)) else $error("sticky lost");
    c_restart: cover property (an_restart);
    c_sif_rd: cover property (rd && ext && a == 5'h11);
    c_soft: cover property (soft_rst);
endmodule : mxp_regs_chk

bind mxp_regs mxp_regs_chk i_chk (.sys_clk, .nrst, .soft_rst,
    .strap_autosense_dis, .strap_serial_mac, .mgmt_req, .mgmt_rdata,
    .mgmt_rvalid, .std_rd, .std_wr, .std_addr, .std_wdata, .std_rdata,
    .lp_abil_valid, .lp_abil, .an_complete, .an_restart, .autosense_dis,
    .rf_map_mask, .rf_map_or, .serial_swing_code, .serial_swing_level,
    .hyst_dis, .aux_clock_output_en, .page_ext);

//--- mxp_tb.sv
// bench for the management register block and its far side model
// assumes both strap pins high, i.e. autosense off and serial mode
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic                   sys_clk, nrst, soft_rst, mgmt_rvalid;
    logic                   strap_autosense_dis, strap_serial_mac;
    mxp_pkg::mxp_mgmt_req_s mgmt_req;
    logic [15:0]            mgmt_rdata, std_wdata, std_rdata;
    logic                   std_rd, std_wr, lp_abil_valid, an_complete;
    logic [4:0]             std_addr;
    mxp_pkg::mxp_lp_abil_s  lp_abil, lp_cfg;
    logic                   an_restart, autosense_dis, rf_map_or;
    logic [1:0]             rf_map_mask;
    logic [2:0]             serial_swing_code, serial_swing_level;
    logic                   hyst_dis, aux_clock_output_en, page_ext;
    int                     err_count, tests_run;
    mxp_regs i_dut (.sys_clk, .nrst, .soft_rst, .strap_autosense_dis,
        .strap_serial_mac, .mgmt_req, .mgmt_rdata, .mgmt_rvalid, .std_rd,
        .std_wr, .std_addr, .std_wdata, .std_rdata, .lp_abil_valid,
        .lp_abil, .an_complete, .an_restart, .autosense_dis, .rf_map_mask,
        .rf_map_or, .serial_swing_code, .serial_swing_level, .hyst_dis,
        .aux_clock_output_en, .page_ext);
    mxp_far_model #(.DLY(12)) i_far (.sys_clk, .nrst, .std_rd, .std_wr,
        .std_addr, .std_wdata, .std_rdata, .an_restart, .lp_cfg,
        .lp_abil_valid, .lp_abil, .an_complete);
    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        tests_run++;
        if (got !== exp) begin
            err_count++;
            $display("mismatch at %0t: got %h want %h", $time, got, exp);
        end
    endtask : check
    // one-cycle write strobe, an idle edge follows before the next
    task automatic mwr(input logic [4:0] a, input logic [15:0] d);
        @(posedge sys_clk);
        #1;
        mgmt_req = '{rd: 1'b0, wr: 1'b1, addr: a, wdata: d};
        @(posedge sys_clk);
        #1;
        mgmt_req = '0;
    endtask : mwr
    // rvalid stands one cycle only, so it is looked at right away
    task automatic mrd(input logic [4:0] a, input logic [15:0] exp);
        @(posedge sys_clk);
        #1;
        mgmt_req = '{rd: 1'b1, wr: 1'b0, addr: a, wdata: 16'h0000};
        @(posedge sys_clk);
        #1;
        mgmt_req = '0;
        check({15'h0, mgmt_rvalid}, 16'h0001);
        check(mgmt_rdata, exp);
    endtask : mrd
    task automatic test_done;
        $display("comparisons %0d, mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : test_done
    // ------------------------------------------------------------
    // clock, watchdog, sequence
    // ------------------------------------------------------------
    initial begin
        sys_clk = 1'b0;
        forever #2 sys_clk = ~sys_clk;
    end
    // the sequence needs well under a thousand cycles
    initial begin
        repeat (20000) @(posedge sys_clk);
        err_count++;
        test_done;
    end
    initial begin
        err_count = 0;
        tests_run = 0;
        nrst = 1'b0;
        soft_rst = 1'b0;
        strap_autosense_dis = 1'b1;
        strap_serial_mac = 1'b1;
        mgmt_req = '0;
        lp_cfg = '0;
        repeat (12) @(posedge sys_clk);
        #1;
        nrst = 1'b1;
        check({15'h0, page_ext}, 16'h0000);
        mrd(5'h10, 16'h5a10);
        mwr(5'h1f, 16'hfffe);
        check({15'h0, page_ext}, 16'h0000);
        mwr(5'h1f, 16'h0001);
        check({15'h0, page_ext}, 16'h0001);
        mrd(5'h1f, 16'h0000);
        mrd(5'h10, 16'h0013);
        mrd(5'h11, 16'h0013);
        for (int a = 18; a <= 30; a++) begin
            mrd(5'(a), 16'h0000);
        end
        mwr(5'h12, 16'hffff);
        mrd(5'h12, 16'h0000);
        mrd(5'h05, 16'h5a05);
        mwr(5'h05, 16'h1234);
        // partner offers rf 10, asym pause and full duplex
        lp_cfg = '{rfault: 2'h2, asym_pause: 1'b1, sym_pause: 1'b0,
                   full_dpx: 1'b1, half_dpx: 1'b0};
        mwr(5'h10, 16'hffff);
        for (int i = 0; i < 100 && an_complete !== 1'b1; i++) begin
            @(posedge sys_clk);
            #1;
        end
        repeat (2) @(posedge sys_clk);
        mrd(5'h10, 16'h2937);
        mwr(5'h10, 16'h0214);
        repeat (3) @(posedge sys_clk);
        mrd(5'h10, 16'h0014);
        for (int c = 0; c < 8; c++) begin
            mwr(5'h11, 16'hffe1 | 16'(c << 2));
            check({13'h0, serial_swing_level}, 16'((c == 7) ? 6 : c));
            mrd(5'h11, 16'h0001 | 16'(c << 2));
        end
        mwr(5'h11, 16'h0000);
        check({14'h0, hyst_dis, aux_clock_output_en}, 16'h0000);
        mwr(5'h1f, 16'h0000);
        mrd(5'h12, 16'h5a12);
        mrd(5'h05, 16'h1234);
        mwr(5'h1f, 16'h0001);
        @(posedge sys_clk);
        #1;
        soft_rst = 1'b1;
        @(posedge sys_clk);
        #1;
        soft_rst = 1'b0;
        check({15'h0, page_ext}, 16'h0000);
        check({11'h0, serial_swing_code, hyst_dis, aux_clock_output_en},
              16'h0013);
        check({12'h0, autosense_dis, rf_map_mask, rf_map_or},
              16'h000c);
        test_done;
    end
endmodule : tb
